//--- dv/acr_chk.sv
`timescale 1ns/10ps
// ****************
// register-side checker
// ****************
module acr_chk (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire acr_pkg::acr_axi_req_type axi_req_in,
  input wire acr_pkg::acr_axi_rsp_type axi_rsp_out,
  input wire logic conv_done_in,
  input wire logic conv_start_out,
  input wire logic converter_clock_en_out,
  input wire logic [4:0] channel_select_out,
  input wire logic mode_ten_bit_out,
  input wire logic conversion_active_out
);
  import acr_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence rd_taken(logic [7:0] a);
    axi_req_in.arvalid && axi_rsp_out.arready && axi_req_in.araddr == a;
  endsequence
  start_active_a: assert property (conv_start_out |-> conversion_active_out)
    else $error("start pulse without active flag");
  active_rise_a: assert property ($rose(conversion_active_out) |-> conv_start_out)
    else $error("active flag rose without start");
  done_clear_a: assert property (conversion_active_out && conv_done_in |=>
    !conversion_active_out || conv_start_out) else $error("active flag kept after done");
  clk_en_idle_a: assert property (converter_clock_en_out |-> conversion_active_out)
    else $error("converter clock while idle");
  start_chan_a: assert property (conv_start_out |-> channel_select_out != CHANNEL_OFF)
    else $error("start with channel off");
  hi_zero_a: assert property (rd_taken(OFF_RES_HI) ##0 !mode_ten_bit_out |=>
    axi_rsp_out.rdata[7:0] == 8'h00) else $error("high result not zero in 8-bit");
  active_read_a: assert property (rd_taken(OFF_SC2) |=>
    axi_rsp_out.rdata[7] == $past(conversion_active_out) && axi_rsp_out.rdata[1:0] == 2'b00)
    else $error("control-two read mismatch");
  unmapped_read_a: assert property (rd_taken(8'h1C) |=>
    axi_rsp_out.rresp == RESP_SLVERR && axi_rsp_out.rdata == 32'h0000_0000) else $error("unmapped read");
  bresp_hold_a: assert property (axi_rsp_out.bvalid && !axi_req_in.bready |=>
    axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (axi_rsp_out.rvalid && !axi_req_in.rready |=>
    axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata)) else $error("read data dropped");
endmodule : acr_chk

bind acr_top acr_chk chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out), .conv_done_in(conv_done_in), .conv_start_out(conv_start_out),
  .converter_clock_en_out(converter_clock_en_out), .channel_select_out(channel_select_out),
  .mode_ten_bit_out(mode_ten_bit_out), .conversion_active_out(conversion_active_out));

//--- dv/adc_compare_result_config_tb_top.sv
`timescale 1ns/10ps
module adc_compare_result_config_tb_top;
  import acr_pkg::*;
  logic clk_in, arst_n_in, hw_trig, alt_clk, done, start, abort, clk_en, lp, ls, ten, act;
  logic [9:0] result;
  logic [4:0] chan;
  logic [7:0] d;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  acr_axi_req_type req;
  acr_axi_rsp_type rsp;
  int n_errors, check_count, cyc, seed, res, cmp_hi, cmp_lo, cfg, sc2, chn, conversion_complete_flag, lock, busy;
  int n_en, n_ab, n_st, r, k, e, a0;

  acr_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .axi_req_in(req), .axi_rsp_out(rsp),
    .hardware_trigger_input_in(hw_trig), .alternate_clock_in(alt_clk),
    .async_converter_clock_in(alt_clk), .conv_done_in(done), .conv_result_in(result),
    .conv_start_out(start), .conv_abort_out(abort), .converter_clock_en_out(clk_en),
    .channel_select_out(chan), .low_power_select_out(lp), .long_sample_select_out(ls),
    .mode_ten_bit_out(ten), .conversion_active_out(act));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ****************
  // counters and hang guard
  // ****************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    alt_clk <= cyc[1];
    n_en <= n_en + int'(clk_en);
    n_ab <= n_ab + int'(abort);
    n_st <= n_st + int'(start);
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("unexpected at %0t expected %h got %h", $time, ex, got);
    end
  endtask : chk

  // ****************
  // bus tasks
  // ****************
  task wr(input logic [7:0] a, input logic [7:0] v);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk_in);
    req.awaddr <= a;
    req.wdata <= {24'h00_0000, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (!aw && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    // late bready makes the slave hold its response
    repeat (2) @(posedge clk_in);
    req.bready <= 1'b1;
    do @(posedge clk_in); while (rsp.bvalid !== 1'b1);
    rd_r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge clk_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    @(posedge clk_in);
    req.rready <= 1'b1;
    do @(posedge clk_in); while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  // ****************
  // reference model
  // ****************
  function automatic logic [7:0] model_rd(input logic [7:0] a);
    case (a)
      OFF_SC1: model_rd = {conversion_complete_flag[0], 1'b0, chn[5:0]};
      OFF_SC2: model_rd = {busy[0], sc2[6:4], 4'h0};
      OFF_RES_HI: model_rd = 8'(res >> 8);
      OFF_RES_LO: model_rd = 8'(res);
      OFF_CMP_HI: model_rd = 8'(cmp_hi);
      OFF_CMP_LO: model_rd = 8'(cmp_lo);
      OFF_CFG: model_rd = 8'(cfg);
      default: model_rd = 8'h00;
    endcase
  endfunction : model_rd

  function automatic bit ok(input int v);
    int c;
    c = cfg[3:2] == 2'b10 ? cmp_hi % 4 * 256 + cmp_lo : cmp_lo;
    if (cfg[3:2] != 2'b10) v = v % 256;
    if (!sc2[5]) return 1'b1;
    return sc2[4] ? v >= c : v < c;
  endfunction : ok

  task rc(input logic [7:0] a);
    rd(a);
    chk(32'(model_rd(a)), rd_d);
    chk(a > OFF_CFG ? 32'(RESP_SLVERR) : 32'(RESP_OKAY), 32'(rd_r));
    if (a == OFF_RES_HI && cfg[3:2] == 2'b10) lock = 1;
    if (a == OFF_RES_LO) begin
      lock = 0;
      conversion_complete_flag = 0;
    end
  endtask : rc

  task wc(input logic [7:0] v);
    if (v[3:2] != cfg[3:2]) res = 0;
    if (v[3:2] != 2'b10) lock = 0;
    cfg = v;
    wr(OFF_CFG, v);
  endtask : wc

  task st(input int c);
    wr(OFF_SC1, 8'(c));
    chn = c;
    conversion_complete_flag = 0;
    busy = !sc2[6] && c % 32 != 31;
    @(posedge clk_in);
    chk(32'(busy), 32'(act));
    chk(32'(c % 32), 32'(chan));
  endtask : st

  task cv(input int v);
    @(posedge clk_in);
    done <= 1'b1;
    result <= 10'(v);
    @(posedge clk_in);
    done <= 1'b0;
    result <= ~10'(v);
    if (busy && ok(v) && !lock) res = cfg[3:2] == 2'b10 ? v : v % 256;
    if (busy && ok(v)) conversion_complete_flag = 1;
    busy = busy && chn[5];
  endtask : cv

  // ****************
  // test sequence
  // ****************
  initial begin
    seed = 32'h0000_65d1;
    chn = 31;
    req = '0;
    hw_trig = 1'b0;
    alt_clk = 1'b0;
    done = 1'b0;
    result = 10'h000;
    arst_n_in = 1'b0;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int a = 0; a <= 28; a += 4) rc(8'(a));
    wr(8'h1C, 8'hff);
    chk(32'(RESP_SLVERR), 32'(rd_r));
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      wc(8'($random(seed)));
      rc(OFF_CFG);
      chk(32'({cfg[7], cfg[4], cfg[3:2] == 2'b10}), 32'({lp, ls, ten}));
    end
    $display("config test done");
    for (int c = 0; c < 4; c++) begin
      wc(8'(c * 32 + c));
      st(c);
      a0 = n_en;
      repeat (64) @(posedge clk_in);
      k = n_en - a0;
      e = (c == 0 ? 64 : c == 1 ? 32 : 16) >> c;
      chk(32'h0000_0001, 32'(k >= e - 1 && k <= e + 1));
      cv($random(seed) & 1023);
    end
    $display("clock test done");
    for (int m = 0; m < 2; m++) begin
      wc(m ? 8'h08 : 8'h00);
      for (int i = 0; i < 12; i++) begin
        sc2 = $random(seed) & 8'h30;
        wr(OFF_SC2, 8'(sc2) | 8'h80);
        r = $random(seed) & 1023;
        cmp_lo = (r + i % 3 - 1) & 255;
        cmp_hi = i % 2 ? $random(seed) & 3 : r >> 8;
        wr(OFF_CMP_LO, 8'(cmp_lo));
        wr(OFF_CMP_HI, 8'(cmp_hi));
        st(i % 4);
        rc(OFF_SC2);
        cv(r);
        rc(OFF_SC1);
        rc(OFF_RES_HI);
        rc(OFF_RES_LO);
      end
    end
    sc2 = 0;
    wr(OFF_SC2, 8'h00);
    $display("compare test done");
    for (int m = 0; m < 2; m++) begin
      wc(m ? 8'h08 : 8'h00);
      st(1);
      cv($random(seed) & 1023);
      rc(OFF_RES_HI);
      st(1);
      cv($random(seed) & 1023);
      rc(OFF_RES_LO);
      rc(OFF_RES_HI);
    end
    wc(8'h08);
    st(2);
    cv($random(seed) & 1023 | 1);
    wc(8'h00);
    rc(OFF_RES_LO);
    $display("interlock test done");
    sc2 = 8'h40;
    wr(OFF_SC2, 8'h40);
    st(3);
    @(posedge clk_in);
    hw_trig <= 1'b1;
    repeat (8) @(posedge clk_in);
    hw_trig <= 1'b0;
    busy = 1;
    rc(OFF_SC2);
    cv($random(seed) & 1023);
    sc2 = 0;
    wr(OFF_SC2, 8'h00);
    st(33);
    cv($random(seed) & 1023);
    rc(OFF_SC2);
    rc(OFF_SC1);
    st(4);
    a0 = n_ab;
    r = n_st;
    st(5);
    st(31);
    repeat (2) @(posedge clk_in);
    chk(32'(2), 32'(n_ab - a0));
    chk(32'(1), 32'(n_st - r));
    rc(OFF_SC2);
    $display("trigger test done");
    test_done();
  end
endmodule : adc_compare_result_config_tb_top

//--- rtl/acr_clk_gen.sv
`timescale 1ns/10ps
module acr_clk_gen #(
  parameter int STAGES = acr_pkg::SYNC_STAGES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic alternate_clock_in,
  input wire logic async_converter_clock_in,
  input wire logic [1:0] input_clock_select_in,
  input wire logic [1:0] clock_divide_in,
  input wire logic run_in,
  output logic converter_clock_en_out
);
  import acr_pkg::*;

  if (STAGES != 3) begin : g_bad
    $error("acr_clk_gen: STAGES must be 3");
  end

  // ****************************************
  // pin clocks sampled, edge when stages agree
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_rise;
  assign pin_raw = {async_converter_clock_in, alternate_clock_in};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic [STAGES-1:0] sync_q;
    logic level_q;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sync_q <= '0;
      end else begin
        sync_q <= {sync_q[STAGES-2:0], pin_raw[i]};
      end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        level_q <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[1];
      end
    end
    assign pin_rise[i] = sync_q[1] & sync_q[2] & ~level_q;
  end

  // ****************************************
  // source select and divider
  // ****************************************
  logic half_q;
  logic src_tick;
  logic [2:0] div_cnt_q;
  logic [2:0] div_last;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  always_comb begin
    unique case (input_clock_select_in)
      CLK_BUS: src_tick = 1'b1;
      CLK_BUS_HALF: src_tick = half_q;
      CLK_ALT: src_tick = pin_rise[0];
      CLK_ASYNC: src_tick = pin_rise[1];
    endcase
  end

  assign div_last = 3'((1 << clock_divide_in) - 1);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_q <= 3'h0;
    end else if (!run_in) begin
      div_cnt_q <= 3'h0;
    end else if (src_tick) begin
      div_cnt_q <= (div_cnt_q >= div_last) ? 3'h0 : div_cnt_q + 3'h1;
    end
  end

  assign converter_clock_en_out = run_in & src_tick & (div_cnt_q >= div_last);
endmodule : acr_clk_gen

//--- rtl/acr_pkg.sv
package acr_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0C;
  localparam logic [7:0] OFF_CMP_HI = 8'h10;
  localparam logic [7:0] OFF_CMP_LO = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SC1_COMPLETE_BIT = 7;
  localparam int SC1_CONTINUOUS_BIT = 5;
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_TRIGGER_BIT = 6;
  localparam int SC2_CMP_EN_BIT = 5;
  localparam int SC2_CMP_GE_BIT = 4;
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIVIDE_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [4:0] RST_CHANNEL = 5'h1F;
  localparam logic [4:0] CHANNEL_OFF = 5'h1F;
  localparam logic [1:0] MODE_EIGHT = 2'b00;
  localparam logic [1:0] MODE_TEN = 2'b10;
  localparam logic [1:0] CLK_BUS = 2'b00;
  localparam logic [1:0] CLK_BUS_HALF = 2'b01;
  localparam logic [1:0] CLK_ALT = 2'b10;
  localparam logic [1:0] CLK_ASYNC = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int SYNC_STAGES = 3;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } acr_state_type;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } acr_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } acr_axi_rsp_type;
endpackage : acr_pkg

//--- rtl/acr_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module acr_top (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire acr_pkg::acr_axi_req_type axi_req_in,
  output acr_pkg::acr_axi_rsp_type axi_rsp_out,
  input wire logic hardware_trigger_input_in,
  input wire logic alternate_clock_in,
  input wire logic async_converter_clock_in,
  input wire logic conv_done_in,
  input wire logic [9:0] conv_result_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  output logic converter_clock_en_out,
  output logic [4:0] channel_select_out,
  output logic low_power_select_out,
  output logic long_sample_select_out,
  output logic mode_ten_bit_out,
  output logic conversion_active_out
);
  import acr_pkg::*;
  // ****************************************
  // register state
  // ****************************************
  logic [4:0] channel_q;
  logic continuous_q, complete_q, trigger_select_q, compare_enable_q, compare_ge_q, lock_q;
  logic [9:0] result_q;
  logic [1:0] cmp_hi_q;
  logic [7:0] cmp_lo_q, cfg_q;
  acr_state_type state_q, state_d;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic aw_have_q, w_have_q, w_strb_q, bvalid_q, wr_commit, wr_mapped;
  logic [7:0] aw_addr_q, w_data_q, wr_addr;
  logic [1:0] bresp_q;
  assign axi_rsp_out.awready = ~aw_have_q & ~bvalid_q;
  assign axi_rsp_out.wready = ~w_have_q & ~bvalid_q;
  assign axi_rsp_out.bvalid = bvalid_q;
  assign axi_rsp_out.bresp = bresp_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (axi_req_in.awvalid && axi_rsp_out.awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {axi_req_in.awaddr[7:2], 2'b00};
    end else if (wr_commit) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (axi_req_in.wvalid && axi_rsp_out.wready) begin
      w_have_q <= 1'b1;
      w_data_q <= axi_req_in.wdata[7:0];
      w_strb_q <= axi_req_in.wstrb[0];
    end else if (wr_commit) begin
      w_have_q <= 1'b0;
    end
  end

  assign wr_commit = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_addr = aw_addr_q;
  assign wr_mapped = (wr_addr <= OFF_CFG);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_in.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  logic wr_en, wr_sc1, wr_sc2, wr_cmp_hi, wr_cmp_lo, wr_cfg;
  assign wr_en = wr_commit & w_strb_q;
  assign wr_sc1 = wr_en & (wr_addr == OFF_SC1);
  assign wr_sc2 = wr_en & (wr_addr == OFF_SC2);
  assign wr_cmp_hi = wr_en & (wr_addr == OFF_CMP_HI);
  assign wr_cmp_lo = wr_en & (wr_addr == OFF_CMP_LO);
  assign wr_cfg = wr_en & (wr_addr == OFF_CFG);

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic rvalid_q, rd_take, rd_res_hi, rd_res_lo, rd_mapped;
  logic [7:0] rdata_q, rd_addr, rd_mux;
  logic [1:0] rresp_q;
  assign axi_rsp_out.arready = ~rvalid_q;
  assign axi_rsp_out.rvalid = rvalid_q;
  assign axi_rsp_out.rdata = {24'h00_0000, rdata_q};
  assign axi_rsp_out.rresp = rresp_q;
  assign rd_take = axi_req_in.arvalid & ~rvalid_q;
  assign rd_addr = {axi_req_in.araddr[7:2], 2'b00};
  assign rd_res_hi = rd_take & (rd_addr == OFF_RES_HI);
  assign rd_res_lo = rd_take & (rd_addr == OFF_RES_LO);
  assign rd_mapped = (rd_addr <= OFF_CFG);

  always_comb begin
    rd_mux = 8'h00;
    unique case (rd_addr)
      OFF_SC1: begin
        rd_mux[SC1_COMPLETE_BIT] = complete_q;
        rd_mux[SC1_CONTINUOUS_BIT] = continuous_q;
        rd_mux[4:0] = channel_q;
      end
      OFF_SC2: begin
        rd_mux[SC2_ACTIVE_BIT] = (state_q == ST_BUSY);
        rd_mux[SC2_TRIGGER_BIT] = trigger_select_q;
        rd_mux[SC2_CMP_EN_BIT] = compare_enable_q;
        rd_mux[SC2_CMP_GE_BIT] = compare_ge_q;
      end
      OFF_RES_HI: rd_mux[1:0] = result_q[9:8];
      OFF_RES_LO: rd_mux = result_q[7:0];
      OFF_CMP_HI: rd_mux[1:0] = cmp_hi_q;
      OFF_CMP_LO: rd_mux = cmp_lo_q;
      OFF_CFG: rd_mux = cfg_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req_in.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic mode_ten, mode_change;
  assign mode_ten = (cfg_q[CFG_MODE_LSB +: 2] == MODE_TEN);
  assign mode_change = wr_cfg & (w_data_q[CFG_MODE_LSB +: 2] != cfg_q[CFG_MODE_LSB +: 2]);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      channel_q <= RST_CHANNEL;
      continuous_q <= 1'b0;
    end else if (wr_sc1) begin
      channel_q <= w_data_q[4:0];
      continuous_q <= w_data_q[SC1_CONTINUOUS_BIT];
    end
  end

  // active bit and reserved low bits are not stored
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trigger_select_q <= 1'b0;
      compare_enable_q <= 1'b0;
      compare_ge_q <= 1'b0;
    end else if (wr_sc2) begin
      trigger_select_q <= w_data_q[SC2_TRIGGER_BIT];
      compare_enable_q <= w_data_q[SC2_CMP_EN_BIT];
      compare_ge_q <= w_data_q[SC2_CMP_GE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp_hi_q <= 2'b00;
    end else if (wr_cmp_hi) begin
      cmp_hi_q <= w_data_q[1:0];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp_lo_q <= 8'h00;
    end else if (wr_cmp_lo) begin
      cmp_lo_q <= w_data_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= RST_REG;
    end else if (wr_cfg) begin
      cfg_q <= w_data_q;
    end
  end

  assign low_power_select_out = cfg_q[CFG_LOW_POWER_BIT];
  assign long_sample_select_out = cfg_q[CFG_LONG_SAMPLE_BIT];
  assign mode_ten_bit_out = mode_ten;
  assign channel_select_out = channel_q;

  // ****************************************
  // hardware trigger pin
  // ****************************************
  logic [SYNC_STAGES-1:0] trig_sync_q;
  logic trig_level_q, trig_rise;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_sync_q <= '0;
    end else begin
      trig_sync_q <= {trig_sync_q[SYNC_STAGES-2:0], hardware_trigger_input_in};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_level_q <= 1'b0;
    end else if (trig_sync_q[1] == trig_sync_q[2]) begin
      trig_level_q <= trig_sync_q[1];
    end
  end

  assign trig_rise = trig_sync_q[1] & trig_sync_q[2] & ~trig_level_q;

  // ****************************************
  // conversion sequencing
  // ****************************************
  logic busy, chan_on, abort, start, done, restart;
  assign busy = (state_q == ST_BUSY);
  assign chan_on = (channel_q != CHANNEL_OFF);
  // an SC1 write aborts even when the trigger pin is the start source
  assign abort = wr_sc1 & busy;
  assign done = conv_done_in & busy & ~wr_sc1;
  assign restart = done & continuous_q & chan_on;
  always_comb begin
    start = 1'b0;
    if (wr_sc1) begin
      start = ~trigger_select_q & (w_data_q[4:0] != CHANNEL_OFF);
    end else if (trigger_select_q && trig_rise && chan_on && !busy) begin
      start = 1'b1;
    end else if (restart) begin
      start = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if ((done || abort) && !start) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_start_out <= 1'b0;
      conv_abort_out <= 1'b0;
    end else begin
      conv_start_out <= start;
      conv_abort_out <= abort;
    end
  end

  assign conversion_active_out = busy;

  // ****************************************
  // compare and result transfer
  // ****************************************
  logic [9:0] new_result, cmp_value;
  logic cmp_true, accept;
  assign new_result = mode_ten ? conv_result_in : {2'b00, conv_result_in[7:0]};
  assign cmp_value = mode_ten ? {cmp_hi_q, cmp_lo_q} : {2'b00, cmp_lo_q};
  assign cmp_true = compare_ge_q ? (new_result >= cmp_value) : (new_result < cmp_value);
  assign accept = done & (~compare_enable_q | cmp_true);

  // interlock: a high read in 10-bit mode holds off transfers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_q <= 1'b0;
    end else if (!mode_ten) begin
      lock_q <= 1'b0;
    end else if (rd_res_hi) begin
      lock_q <= 1'b1;
    end else if (rd_res_lo) begin
      lock_q <= 1'b0;
    end
  end

  // a result finished while locked is dropped, not queued
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_q <= 10'h000;
    end else if (mode_change) begin
      result_q <= 10'h000;
    end else if (accept && !lock_q) begin
      result_q <= new_result;
    end
  end

  // complete flag: a finishing conversion beats a low-result read; an SC1 write masks done and clears it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      complete_q <= 1'b0;
    end else if (accept) begin
      complete_q <= 1'b1;
    end else if (wr_sc1 || rd_res_lo) begin
      complete_q <= 1'b0;
    end
  end

  // ****************************************
  // converter clock
  // ****************************************
  acr_clk_gen #(
    .STAGES(SYNC_STAGES)
  ) u_clk_gen (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .alternate_clock_in(alternate_clock_in),
    .async_converter_clock_in(async_converter_clock_in),
    .input_clock_select_in(cfg_q[CFG_CLK_LSB +: 2]),
    .clock_divide_in(cfg_q[CFG_DIVIDE_LSB +: 2]),
    .run_in(busy),
    .converter_clock_en_out(converter_clock_en_out)
  );
endmodule : acr_top
